//--- rtl/ifj_cfg.svh
// Purpose: named constants for the increment and absolute jump execution block
// Assumes: 16-bit instruction words, 12-bit data address, 21-bit program counter
// Notes:   each constant is named once here; the figure 4'hf backs three of them
`ifndef IFJ_CFG_SVH
`define IFJ_CFG_SVH
`define IFJ_OPC_INC        6'h0a
`define IFJ_OPC_JMP1       8'hef
`define IFJ_OPC_JMP2       4'hf
`define IFJ_IDX_LIMIT      8'h5f
`define IFJ_ACC_SPLIT      8'h60
`define IFJ_ACC_HI_BANK    4'hf
`define IFJ_ACC_LO_BANK    4'h0
`define IFJ_PC_RESET       21'h00_0000
`define IFJ_FLAGS_RESET    5'h00
`define IFJ_BYTE_ZERO      8'h00
`define IFJ_BYTE_ONE       8'h01
`define IFJ_ADDR_ZERO      12'h000
`define IFJ_NIB_MAX        4'hf
`define IFJ_BYTE_SIGNMAX   8'h7f
`endif

//--- rtl/ifj_pkg.sv
// Purpose: shared types for the increment and absolute jump execution block
// Assumes: four quarter phases per instruction cycle
// Notes:   flags are packed in status bit order n, ov, z, dc, c
package ifj_pkg;
   typedef enum logic [1:0] {
      IFJ_Q1 = 2'b00,
      IFJ_Q2 = 2'b01,
      IFJ_Q3 = 2'b10,
      IFJ_Q4 = 2'b11
   } ifj_phase_t;

   typedef enum logic [1:0] {
      IFJ_ST_IDLE  = 2'b00,
      IFJ_ST_INC   = 2'b01,
      IFJ_ST_JMP   = 2'b10,
      IFJ_ST_FLUSH = 2'b11
   } ifj_state_t;

   typedef struct packed {
      logic negative_flag;
      logic overflow_flag;
      logic zero_flag;
      logic digit_carry_flag;
      logic carry_flag;
   } ifj_flags_t;

   typedef struct packed {
      logic [7:0] result;
      ifj_flags_t flags;
   } ifj_alu_out_t;
endpackage : ifj_pkg

//--- rtl/ifj_inc_alu.sv
// Purpose: byte incrementer with status flag generation
// Assumes: purely combinational, operand stable during the process phase
// Notes:   carry out of bit 7 is the carry flag, out of bit 3 the digit carry
`timescale 1ns/10ps
`include "ifj_cfg.svh"
module ifj_inc_alu (
   // operand
   input  wire logic [7:0]            operand,
   // result and flags
   output ifj_pkg::ifj_alu_out_t      alu_out
);
   logic [8:0] sum;
   logic [4:0] low_sum;

   always_comb begin
      sum     = {1'b0, operand} + {1'b0, `IFJ_BYTE_ONE};                      // RL1
      low_sum = {1'b0, operand[3:0]} + 5'h01;
      alu_out.result                 = sum[7:0];                                 // RL1
      alu_out.flags.carry_flag       = sum[8];                                   // RL7
      alu_out.flags.digit_carry_flag = low_sum[4];                               // RL7
      alu_out.flags.zero_flag        = (sum[7:0] == `IFJ_BYTE_ZERO);             // RL7
      alu_out.flags.negative_flag    = sum[7];                                   // RL7
      // adding +1 overflows only from the largest positive value
      alu_out.flags.overflow_flag    = (operand == `IFJ_BYTE_SIGNMAX);           // RL7
   end
endmodule : ifj_inc_alu

//--- rtl/ifj_exec.sv
// Purpose: executes the increment-file and absolute-jump instructions of the core
// Assumes: phase input from the core clock divider, one instruction word per cycle
// Notes:   data memory sits outside; read data must be valid in the same phase as the address
//
// How it works
// RL1: increment reads the addressed byte and adds one modulo 256
// RL2: destination bit 0 writes result to working register, file byte untouched
// RL3: destination bit 1 writes result back to the addressed file register
// RL4: bank bit 0 resolves the address inside the access bank
// RL5: bank bit 1 joins bank select register with the 8-bit address
// RL6: bank 0, extended set on, address up to 95 uses indexed literal offset
// RL7: increment updates carry, digit carry, negative, overflow and zero flags
// RL8: jump reads upper literal and writes program counter in last phase
// RL9: jump loads its 20-bit literal into program counter bits 20 to 1
// RL10: jump always takes two cycles, second flushes the fetched instruction
// RL11: increment opcode is 001010 then d, a and 8-bit address, one word
// RL12: increment decodes, reads, processes and writes in the four phases
`timescale 1ns/10ps
`include "ifj_cfg.svh"
module ifj_exec (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 nrst,
   // instruction stream
   input  wire ifj_pkg::ifj_phase_t  phase,
   input  wire logic [15:0]          instr_word,
   input  wire logic                 instr_valid,
   // core state
   input  wire logic [3:0]           bank_select_register,
   input  wire logic [11:0]          index_base,
   input  wire logic                 ext_set_enable,
   input  wire logic [7:0]           mem_rdata,
   // data memory port
   output logic [11:0]               mem_addr,
   output logic                      mem_rd,
   output logic                      mem_we,
   output logic [7:0]                mem_wdata,
   // working register write
   output logic                      wreg_we,
   output logic [7:0]                wreg_wdata,
   // status and program counter
   output ifj_pkg::ifj_flags_t       status_flags,
   output logic                      status_we,
   output logic [20:0]               pc,
   output logic                      pc_load,
   output logic                      flush,
   output logic                      busy
);
   logic                      rst_meta;
   logic                      rst_sync;
   ifj_pkg::ifj_state_t       state;
   logic                      dest_file;
   logic [7:0]                low_literal;
   logic [7:0]                operand;
   ifj_pkg::ifj_alu_out_t     alu_out;
   ifj_pkg::ifj_alu_out_t     alu_held;
   logic [11:0]               next_addr;

   function automatic logic is_inc(input logic [15:0] w);
      is_inc = (w[15:10] == `IFJ_OPC_INC);                                       // RL11
   endfunction : is_inc

   function automatic logic is_jmp1(input logic [15:0] w);
      is_jmp1 = (w[15:8] == `IFJ_OPC_JMP1);
   endfunction : is_jmp1

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // data address resolution
   always_comb begin
      next_addr = `IFJ_ADDR_ZERO;
      if (instr_word[8]) begin
         next_addr = {bank_select_register, instr_word[7:0]};                    // RL5
      end else if (ext_set_enable && (instr_word[7:0] <= `IFJ_IDX_LIMIT)) begin
         next_addr = index_base + {4'h0, instr_word[7:0]};                       // RL6
      end else if (instr_word[7:0] < `IFJ_ACC_SPLIT) begin
         next_addr = {`IFJ_ACC_LO_BANK, instr_word[7:0]};                        // RL4
      end else begin
         // upper access range, 8'h60 and above, maps onto the special function registers
         next_addr = {`IFJ_ACC_HI_BANK, instr_word[7:0]};                        // RL4
      end
   end

   ifj_inc_alu u_alu (
      .operand (operand),
      .alu_out (alu_out)
   );

   // sequencing across the quarter phases
   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
         state <= ifj_pkg::IFJ_ST_IDLE;
      end else begin
         case (state)
            ifj_pkg::IFJ_ST_IDLE: begin
               if (phase == ifj_pkg::IFJ_Q1 && instr_valid) begin
                  if (is_inc(instr_word)) begin
                     state <= ifj_pkg::IFJ_ST_INC;                                // RL12
                  end else if (is_jmp1(instr_word)) begin
                     state <= ifj_pkg::IFJ_ST_JMP;
                  end
               end
            end
            ifj_pkg::IFJ_ST_INC: begin
               if (phase == ifj_pkg::IFJ_Q4) begin
                  state <= ifj_pkg::IFJ_ST_IDLE;                                  // RL12
               end
            end
            ifj_pkg::IFJ_ST_JMP: begin
               if (phase == ifj_pkg::IFJ_Q4) begin
                  state <= ifj_pkg::IFJ_ST_FLUSH;                                 // RL10
               end
            end
            ifj_pkg::IFJ_ST_FLUSH: begin
               // the whole second cycle is a no-operation
               if (phase == ifj_pkg::IFJ_Q4) begin
                  state <= ifj_pkg::IFJ_ST_IDLE;                                  // RL10
               end
            end
            default: begin
               state <= ifj_pkg::IFJ_ST_IDLE;
            end
         endcase
      end
   end

   // decode phase latches fields of the current word
   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
         dest_file   <= 1'b0;
         low_literal <= `IFJ_BYTE_ZERO;
         mem_addr    <= `IFJ_ADDR_ZERO;
      end else if (state == ifj_pkg::IFJ_ST_IDLE && phase == ifj_pkg::IFJ_Q1 && instr_valid) begin
         dest_file   <= instr_word[9];                                           // RL11
         low_literal <= instr_word[7:0];
         if (is_inc(instr_word)) begin
            mem_addr <= next_addr;
         end
      end
   end

   // operand read in phase two, arithmetic held in phase three
   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
         mem_rd  <= 1'b0;
         operand <= `IFJ_BYTE_ZERO;
         alu_held <= '0;
      end else begin
         mem_rd <= (state == ifj_pkg::IFJ_ST_IDLE) && (phase == ifj_pkg::IFJ_Q1)
                   && instr_valid && is_inc(instr_word);                         // RL12
         if (state == ifj_pkg::IFJ_ST_INC && phase == ifj_pkg::IFJ_Q2) begin
            operand <= mem_rdata;                                                // RL1
         end
         if (state == ifj_pkg::IFJ_ST_INC && phase == ifj_pkg::IFJ_Q3) begin
            alu_held <= alu_out;                                                 // RL12
         end
      end
   end

   // destination write in phase four
   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
         mem_we       <= 1'b0;
         mem_wdata    <= `IFJ_BYTE_ZERO;
         wreg_we      <= 1'b0;
         wreg_wdata   <= `IFJ_BYTE_ZERO;
         status_we    <= 1'b0;
         status_flags <= `IFJ_FLAGS_RESET;
      end else begin
         mem_we    <= 1'b0;
         wreg_we   <= 1'b0;
         status_we <= 1'b0;
         if (state == ifj_pkg::IFJ_ST_INC && phase == ifj_pkg::IFJ_Q4) begin
            if (dest_file) begin
               mem_we    <= 1'b1;                                                // RL3
               mem_wdata <= alu_held.result;                                     // RL3
            end else begin
               wreg_we    <= 1'b1;                                               // RL2
               wreg_wdata <= alu_held.result;                                    // RL2
            end
            status_we    <= 1'b1;                                                // RL7
            status_flags <= alu_held.flags;                                      // RL7
         end
      end
   end

   // program counter load and flush signalling
   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
         pc      <= `IFJ_PC_RESET;
         pc_load <= 1'b0;
         flush   <= 1'b0;
         busy    <= 1'b0;
      end else begin
         pc_load <= 1'b0;
         if (state == ifj_pkg::IFJ_ST_JMP && phase == ifj_pkg::IFJ_Q4) begin
            // second word must carry the 1111 prefix; otherwise the jump is dropped
            if (instr_word[15:12] == `IFJ_OPC_JMP2) begin
               pc      <= {instr_word[11:0], low_literal, 1'b0};                 // RL9
               pc_load <= 1'b1;                                                  // RL8
            end
         end
         flush <= (state == ifj_pkg::IFJ_ST_JMP && phase == ifj_pkg::IFJ_Q4)
                  || (state == ifj_pkg::IFJ_ST_FLUSH && phase != ifj_pkg::IFJ_Q4); // RL10
         busy  <= (state != ifj_pkg::IFJ_ST_IDLE) && !(phase == ifj_pkg::IFJ_Q4
                  && (state == ifj_pkg::IFJ_ST_INC || state == ifj_pkg::IFJ_ST_FLUSH));
      end
   end
endmodule : ifj_exec

//--- verif/ifj_exec_assertions.sv
// Purpose: concurrent checks on the increment and absolute jump execution block
// Assumes: phase advances one quarter per clock, as the core divider gives it
// Notes:   expected address and operand are rebuilt from the ports, not the body
`timescale 1ns/10ps
`include "ifj_cfg.svh"
module ifj_exec_assertions (
   // clock and reset
   input wire logic                clock,
   input wire logic                nrst,
   // instruction and core state
   input wire ifj_pkg::ifj_phase_t phase,
   input wire logic [15:0]         instr_word,
   input wire logic                instr_valid,
   input wire logic [3:0]          bank_select_register,
   input wire logic [11:0]         index_base,
   input wire logic                ext_set_enable,
   input wire logic [7:0]          mem_rdata,
   // results
   input wire logic [11:0]         mem_addr,
   input wire logic                mem_rd,
   input wire logic                mem_we,
   input wire logic [7:0]          mem_wdata,
   input wire logic                wreg_we,
   input wire logic [7:0]          wreg_wdata,
   input wire ifj_pkg::ifj_flags_t status_flags,
   input wire logic                status_we,
   input wire logic [20:0]         pc,
   input wire logic                pc_load,
   input wire logic                flush
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   logic        dec_inc;
   logic        dec_jmp;
   logic        dest_seen;
   logic [7:0]  op_seen;
   logic [7:0]  jump_low;
   logic [7:0]  f;
   logic [11:0] ea;
   logic [11:0] ea_seen;
   logic [15:0] w_prev;
   assign f = instr_word[7:0];
   assign dec_inc = phase == ifj_pkg::IFJ_Q1 && instr_valid && !flush
                    && instr_word[15:10] == `IFJ_OPC_INC;
   assign dec_jmp = phase == ifj_pkg::IFJ_Q1 && instr_valid && !flush
                    && instr_word[15:8] == `IFJ_OPC_JMP1;
   // indexed window wins over the access bank split when enabled
   assign ea = instr_word[8] ? {bank_select_register, f}
             : (ext_set_enable && f <= 8'h5f) ? index_base + {4'h0, f}
             : {(f < 8'h60) ? 4'h0 : 4'hf, f};
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         dest_seen <= 1'b0;
         ea_seen   <= 12'h000;
      end else if (dec_inc) begin
         dest_seen <= instr_word[9];
         ea_seen   <= ea;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         jump_low <= 8'h00;
         w_prev   <= 16'h0000;
         op_seen  <= 8'h00;
      end else begin
         w_prev <= instr_word;
         if (dec_jmp) jump_low <= f;
         if (mem_rd) op_seen <= mem_rdata;
      end
   end
   a_rd_after_decode: assert property (dec_inc |=> mem_rd)
      else $error("no operand read after increment decode");
   a_addr_resolve: assert property (mem_rd |-> mem_addr == ea_seen)
      else $error("operand address wrong");
   a_rd_one_clock: assert property (mem_rd |=> !mem_rd [*3])
      else $error("operand read not a single pulse per cycle");
   a_write_phase: assert property (mem_rd |-> ##3 status_we && (mem_we != wreg_we))
      else $error("write not in the phase after process");
   a_dest_select: assert property (status_we |->
      mem_we == dest_seen && wreg_we == !dest_seen)
      else $error("wrong destination written");
   a_inc_result: assert property (status_we |->
      (dest_seen ? mem_wdata : wreg_wdata) == op_seen + 8'h01)
      else $error("increment result wrong");
   a_flag_wrap: assert property (status_we |->
      status_flags.zero_flag == (op_seen == 8'hff)
      && status_flags.carry_flag == (op_seen == 8'hff)
      && status_flags.overflow_flag == (op_seen == 8'h7f)
      && status_flags.digit_carry_flag == (op_seen[3:0] == 4'hf))
      else $error("status flags wrong");
   a_pc_target: assert property (pc_load |-> flush && pc == {w_prev[11:0], jump_low, 1'b0})
      else $error("jump target wrong");
   a_flush_span: assert property ($rose(flush) |-> flush [*4] ##1 !flush)
      else $error("flush not one full cycle");
   a_flush_refuse: assert property (flush && phase == ifj_pkg::IFJ_Q1 |=> !mem_rd)
      else $error("word accepted during flush");
   c_inc_file: cover property (status_we && mem_we);
   c_inc_wreg: cover property (status_we && wreg_we);
   c_jump: cover property (pc_load);
   // a second word without the prefix still costs the flush cycle
   c_jump_refused: cover property ($rose(flush) && !pc_load);
endmodule : ifj_exec_assertions
bind ifj_exec ifj_exec_assertions u_chk (
   .clock                (clock),
   .nrst                 (nrst),
   .phase                (phase),
   .instr_word           (instr_word),
   .instr_valid          (instr_valid),
   .bank_select_register (bank_select_register),
   .index_base           (index_base),
   .ext_set_enable       (ext_set_enable),
   .mem_rdata            (mem_rdata),
   .mem_addr             (mem_addr),
   .mem_rd               (mem_rd),
   .mem_we               (mem_we),
   .mem_wdata            (mem_wdata),
   .wreg_we              (wreg_we),
   .wreg_wdata           (wreg_wdata),
   .status_flags         (status_flags),
   .status_we            (status_we),
   .pc                   (pc),
   .pc_load              (pc_load),
   .flush                (flush)
);

//--- verif/ifj_exec_tb.sv
// Purpose: directed bench for the increment and absolute jump execution block
// Assumes: bench owns phase and moves every input 1 ns after the rising edge
// Notes:   data memory is a held read value; each task starts and ends in Q1
`timescale 1ns/10ps
module ifj_exec_tb;
   logic        clock, nrst, instr_valid, ext_set_enable, mem_rd, mem_we;
   logic        wreg_we, status_we, pc_load, flush, busy;
   logic [15:0] instr_word;
   logic [3:0]  bank_select_register;
   logic [11:0] index_base, mem_addr;
   logic [7:0]  mem_rdata, mem_wdata, wreg_wdata;
   logic [20:0] pc;
   ifj_pkg::ifj_phase_t phase;
   ifj_pkg::ifj_flags_t status_flags;
   int error_cnt = 0;
   int n_compared = 0;
   ifj_exec u_dut (
      .clock                (clock),
      .nrst                 (nrst),
      .phase                (phase),
      .instr_word           (instr_word),
      .instr_valid          (instr_valid),
      .bank_select_register (bank_select_register),
      .index_base           (index_base),
      .ext_set_enable       (ext_set_enable),
      .mem_rdata            (mem_rdata),
      .mem_addr             (mem_addr),
      .mem_rd               (mem_rd),
      .mem_we               (mem_we),
      .mem_wdata            (mem_wdata),
      .wreg_we              (wreg_we),
      .wreg_wdata           (wreg_wdata),
      .status_flags         (status_flags),
      .status_we            (status_we),
      .pc                   (pc),
      .pc_load              (pc_load),
      .flush                (flush),
      .busy                 (busy)
   );
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic tick(int n);
      repeat (n) begin
         @(posedge clock);
         #1;
         phase = ifj_pkg::ifj_phase_t'(phase + 2'd1);
      end
   endtask : tick
   task automatic chk(string what, logic [20:0] exp, logic [20:0] got);
      n_compared++;
      if (exp !== got) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic inc_t(logic d, logic a, logic [7:0] f, logic [7:0] op, logic [11:0] ea);
      logic [7:0] r;
      r = op + 8'h01;
      instr_word = {6'h0a, d, a, f};
      instr_valid = 1'b1;
      mem_rdata = op;
      tick(1);
      instr_valid = 1'b0;
      chk("mem_rd", 1, mem_rd);
      chk("mem_addr", ea, mem_addr);
      tick(1);
      chk("busy", 1, busy);
      tick(2);
      chk("busy", 0, busy);
      chk("mem_we", d, mem_we);
      chk("wreg_we", !d, wreg_we);
      chk("result", r, d ? mem_wdata : wreg_wdata);
      chk("flags", {r[7], op == 8'h7f, r == 8'h00, op[3:0] == 4'hf, op == 8'hff},
          status_flags);
      $display("increment at %h done", f);
   endtask : inc_t
   task automatic jmp_t(logic [7:0] lo, logic [11:0] hi);
      instr_word = {8'hef, lo};
      instr_valid = 1'b1;
      tick(1);
      instr_valid = 1'b0;
      tick(2);
      chk("busy", 1, busy);
      instr_word = {4'hf, hi};
      tick(1);
      chk("pc_load", 1, pc_load);
      chk("pc", {hi, lo, 1'b0}, pc);
      // a valid increment in the flush cycle must be dropped
      instr_word = 16'h2b20;
      instr_valid = 1'b1;
      tick(1);
      instr_valid = 1'b0;
      chk("mem_rd", 0, mem_rd);
      tick(2);
      chk("flush", 1, flush);
      tick(1);
      chk("flush", 0, flush);
      chk("busy", 0, busy);
      $display("jump test done");
   endtask : jmp_t
   task automatic jmp_bad_t(logic [7:0] lo, logic [20:0] pc_old);
      instr_word = {8'hef, lo};
      instr_valid = 1'b1;
      tick(1);
      instr_valid = 1'b0;
      tick(2);
      // second word lacks the 1111 prefix: nothing loads, flush still runs
      instr_word = 16'h0abc;
      tick(1);
      chk("pc_load", 0, pc_load);
      chk("pc", pc_old, pc);
      chk("flush", 1, flush);
      tick(3);
      chk("busy", 1, busy);
      tick(1);
      chk("flush", 0, flush);
      $display("refused jump test done");
   endtask : jmp_bad_t
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   initial begin
      repeat (500) @(posedge clock);
      error_cnt++;
      $display("Error watchdog expected done seen hang");
      summarize();
   end
   initial begin
      nrst = 1'b0;
      phase = ifj_pkg::IFJ_Q1;
      instr_word = 16'h0000;
      instr_valid = 1'b0;
      ext_set_enable = 1'b0;
      bank_select_register = 4'h5;
      index_base = 12'h100;
      mem_rdata = 8'h00;
      repeat (3) @(posedge clock);
      #1 nrst = 1'b1;
      tick(4);
      inc_t(1'b1, 1'b0, 8'h10, 8'hff, 12'h010);
      inc_t(1'b0, 1'b1, 8'h80, 8'h7f, 12'h580);
      ext_set_enable = 1'b1;
      inc_t(1'b1, 1'b0, 8'h5f, 8'h0f, 12'h15f);
      inc_t(1'b0, 1'b0, 8'h60, 8'h12, 12'hf60);
      jmp_t(8'h34, 12'h9ab);
      jmp_bad_t(8'h56, {12'h9ab, 8'h34, 1'b0});
      inc_t(1'b1, 1'b1, 8'h00, 8'h00, 12'h500);
      summarize();
   end
endmodule : ifj_exec_tb
